// file: verilog/htdv_cfg.svh
// constants of the holding tank debug view: offsets, field positions, reset values
`ifndef HTDV_CFG_SVH
`define HTDV_CFG_SVH

////////////////////////////////////////////////////////////////////////////////
// register byte offsets
`define HTDV_OFS_PTR_A      12'h008
`define HTDV_OFS_PTR_B      12'h00C
`define HTDV_OFS_CTRL_UP    12'h010
`define HTDV_OFS_CTRL_LO    12'h014
`define HTDV_OFS_SEL        12'h024

////////////////////////////////////////////////////////////////////////////////
// upper control half field positions
`define HTDV_UP_WHOLE       29
`define HTDV_UP_FOUR        28
`define HTDV_UP_IMM_SWAP    27
`define HTDV_UP_SHARE_HI    26
`define HTDV_UP_SHARE_LO    22
`define HTDV_UP_DWORD       19
`define HTDV_UP_ERR_HI      18
`define HTDV_UP_ERR_LO      17
`define HTDV_UP_SOB         16
`define HTDV_UP_TRUST       15
`define HTDV_UP_SRC_HI      10
`define HTDV_UP_SRC_LO      8
`define HTDV_UP_TAG_HI      2
`define HTDV_UP_TAG_LO      0

////////////////////////////////////////////////////////////////////////////////
// lower control half field positions
`define HTDV_LO_OCTX_HI     31
`define HTDV_LO_OCTX_LO     21
`define HTDV_LO_ODOM_HI     19
`define HTDV_LO_ODOM_LO     16
`define HTDV_LO_PCTX_HI     15
`define HTDV_LO_PCTX_LO     5
`define HTDV_LO_PSEC        4
`define HTDV_LO_PDOM_HI     3
`define HTDV_LO_PDOM_LO     0

////////////////////////////////////////////////////////////////////////////////
// select field and reset values
`define HTDV_SEL_BIT        0
`define HTDV_RST_SEL        1'h0
`define HTDV_RST_WORD       32'h0000_0000

`endif

// file: verilog/htdv_pkg.sv
// types shared by the holding tank debug view
package htdv_pkg;

   // job source codes
   typedef enum logic [2:0] {
      HTDV_SRC_RING0   = 3'h0,
      HTDV_SRC_RING1   = 3'h1,
      HTDV_SRC_RING2   = 3'h2,
      HTDV_SRC_CHECKER = 3'h4
   } htdv_src_t;

   // tank error codes
   typedef enum logic [1:0] {
      HTDV_ERR_NONE = 2'h0,
      HTDV_ERR_LEN  = 2'h1,
      HTDV_ERR_BUS  = 2'h2,
      HTDV_ERR_RSVD = 2'h3
   } htdv_err_t;

   // register decode
   typedef enum logic [2:0] {
      HTDV_REG_NONE  = 3'h0,
      HTDV_REG_PTR_A = 3'h1,
      HTDV_REG_PTR_B = 3'h2,
      HTDV_REG_UP    = 3'h3,
      HTDV_REG_LO    = 3'h4,
      HTDV_REG_SEL   = 3'h5
   } htdv_reg_t;

endpackage : htdv_pkg

// file: verilog/htdv_tank_mem.sv
// per-tank storage with one write port and a registered read port
`timescale 1ns/1ps

module htdv_tank_mem
   import htdv_pkg::*;
#(
   parameter int WIDTH = 96,
   parameter int DEPTH = 2,
   parameter int AW    = 1
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // write port
   input  wire logic             wr_en,
   input  wire logic [AW-1:0]    wr_addr,
   input  wire logic [WIDTH-1:0] wr_data,
   // read port
   input  wire logic [AW-1:0]    rd_addr,
   output logic      [WIDTH-1:0] rd_data
);

   logic [WIDTH-1:0] mem_reg [DEPTH];

   // refuse a depth that the address cannot reach
   if (DEPTH < 1 || DEPTH > (1 << AW)) begin : g_bad_depth
      $error("htdv_tank_mem: DEPTH does not fit AW");
   end

   // storage, cleared at reset so an empty tank reads zero
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < DEPTH; i++) mem_reg[i] <= '0;
      end else if (wr_en) begin
         mem_reg[wr_addr] <= wr_data;
      end
   end

   // registered read
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) rd_data <= '0;
      else        rd_data <= mem_reg[rd_addr];
   end

endmodule : htdv_tank_mem

// file: verilog/htdv_view.sv
// holding tank debug view: tank store, select register and read-only register port
`timescale 1ns/1ps
`include "htdv_cfg.svh"

module htdv_view
   import htdv_pkg::*;
#(
   parameter int NUM_TANKS = 2,
   parameter bit PREFETCH  = 1'b1
) (
   // clock and reset
   input  wire logic        SYS_CLK,
   input  wire logic        RST_N,
   // register port
   input  wire logic [11:0] ADDR,
   input  wire logic [31:0] WDATA,
   input  wire logic        WR,
   input  wire logic        RD,
   output logic      [31:0] RDATA,
   // tank load from the queue controller
   input  wire logic        LOAD,
   input  wire logic        LOAD_TANK,
   input  wire logic [31:0] LOAD_SD_PTR,
   input  wire logic        LOAD_WHOLE,
   input  wire logic        LOAD_FOUR,
   input  wire logic        LOAD_IMM_SWAP,
   input  wire logic [4:0]  LOAD_SHARE_SRC,
   input  wire logic        LOAD_DWORD_ORDER,
   input  wire logic [1:0]  LOAD_ERR,
   input  wire logic        LOAD_SOB,
   input  wire logic        LOAD_ALLOW_TRUSTED,
   input  wire logic [2:0]  LOAD_JOB_SRC,
   input  wire logic [2:0]  LOAD_JOB_TAG,
   input  wire logic [10:0] LOAD_OUT_CTX,
   input  wire logic [3:0]  LOAD_OUT_DOM,
   input  wire logic [10:0] LOAD_PRIM_CTX,
   input  wire logic        LOAD_PRIM_SEC,
   input  wire logic [3:0]  LOAD_PRIM_DOM,
   // configuration
   input  wire logic        WORD_SWAP_CFG,
   input  wire logic        SPLIT_OUT_CFG,
   input  wire logic        ACC_DATA_WRITE,
   // attributes and flags of the selected tank
   output logic [10:0]      VIEW_ATTR_CTX,
   output logic [3:0]       VIEW_ATTR_DOM,
   output logic             VIEW_ATTR_SEC,
   output logic             VIEW_SRC_RSVD,
   output logic             VIEW_FULL_DESC
);

   localparam int W = 96;

   // refuse a tank count that the one-bit select cannot serve
   if (NUM_TANKS < 1 || NUM_TANKS > 2) begin : g_bad_tanks
      $error("htdv_view: NUM_TANKS must be 1 or 2");
   end

   ////////////////////////////////////////////////////////////////////////////
   // register decode
   function automatic htdv_reg_t reg_decode(input logic [11:0] a);
      unique case (a)
         `HTDV_OFS_PTR_A:   reg_decode = HTDV_REG_PTR_A;
         `HTDV_OFS_PTR_B:   reg_decode = HTDV_REG_PTR_B;
         `HTDV_OFS_CTRL_UP: reg_decode = HTDV_REG_UP;
         `HTDV_OFS_CTRL_LO: reg_decode = HTDV_REG_LO;
         `HTDV_OFS_SEL:     reg_decode = HTDV_REG_SEL;
         default:           reg_decode = HTDV_REG_NONE;
      endcase
   endfunction : reg_decode

   htdv_reg_t   reg_hit;
   logic        sel_wr;
   logic        sel_reg;
   logic        sel_next;
   logic        wr_sel_val;
   logic [31:0] up_word;
   logic [31:0] lo_word;
   logic [1:0]  err_keep;
   logic        sob_keep;
   logic [W-1:0] mem_q;
   logic [31:0] q_ptr;
   logic [31:0] q_up;
   logic [31:0] q_lo;
   logic [31:0] ptr_a;
   logic [31:0] ptr_b;
   logic [31:0] rdata_next;
   logic [10:0] ctx_next;
   logic [3:0]  dom_next;
   logic        src_rsvd_next;

   assign reg_hit = reg_decode(ADDR);

   ////////////////////////////////////////////////////////////////////////////
   // tank select: only the select register takes writes, view registers ignore them
   assign sel_wr     = WR && (reg_hit == HTDV_REG_SEL);
   assign wr_sel_val = WDATA[`HTDV_SEL_BIT];
   // an index past the last tank stores zero
   assign sel_next   = sel_wr ? ((32'(wr_sel_val) < NUM_TANKS) ? wr_sel_val : 1'b0) : sel_reg;

   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) sel_reg <= `HTDV_RST_SEL;
      else        sel_reg <= sel_next;
   end

   ////////////////////////////////////////////////////////////////////////////
   // prefetch fields exist only when prefetching is built in
   assign err_keep = PREFETCH ? LOAD_ERR : HTDV_ERR_NONE;
   assign sob_keep = PREFETCH ? LOAD_SOB : 1'b0;

   // pack the upper control half; step and single-job positions stay zero
   always_comb begin
      up_word                                     = `HTDV_RST_WORD;
      up_word[`HTDV_UP_WHOLE]                     = LOAD_WHOLE;
      up_word[`HTDV_UP_FOUR]                      = LOAD_FOUR;
      up_word[`HTDV_UP_IMM_SWAP]                  = LOAD_IMM_SWAP;
      up_word[`HTDV_UP_SHARE_HI:`HTDV_UP_SHARE_LO] = LOAD_SHARE_SRC;
      up_word[`HTDV_UP_DWORD]                     = LOAD_DWORD_ORDER;
      up_word[`HTDV_UP_ERR_HI:`HTDV_UP_ERR_LO]    = err_keep;
      up_word[`HTDV_UP_SOB]                       = sob_keep;
      up_word[`HTDV_UP_TRUST]                     = LOAD_ALLOW_TRUSTED;
      up_word[`HTDV_UP_SRC_HI:`HTDV_UP_SRC_LO]    = LOAD_JOB_SRC;
      up_word[`HTDV_UP_TAG_HI:`HTDV_UP_TAG_LO]    = LOAD_JOB_TAG;
   end

   // pack the lower control half
   always_comb begin
      lo_word                                    = `HTDV_RST_WORD;
      lo_word[`HTDV_LO_OCTX_HI:`HTDV_LO_OCTX_LO] = LOAD_OUT_CTX;
      lo_word[`HTDV_LO_ODOM_HI:`HTDV_LO_ODOM_LO] = LOAD_OUT_DOM;
      lo_word[`HTDV_LO_PCTX_HI:`HTDV_LO_PCTX_LO] = LOAD_PRIM_CTX;
      lo_word[`HTDV_LO_PSEC]                     = LOAD_PRIM_SEC;
      lo_word[`HTDV_LO_PDOM_HI:`HTDV_LO_PDOM_LO] = LOAD_PRIM_DOM;
   end

   ////////////////////////////////////////////////////////////////////////////
   // tank storage, read at the next select so a fresh select shows at once
   htdv_tank_mem #(
      .WIDTH (W),
      .DEPTH (NUM_TANKS),
      .AW    (1)
   ) u_mem (
      .clk     (SYS_CLK),
      .rst_n   (RST_N),
      .wr_en   (LOAD),
      .wr_addr (LOAD_TANK),
      .wr_data ({LOAD_SD_PTR, up_word, lo_word}),
      .rd_addr (sel_next),
      .rd_data (mem_q)
   );

   assign q_ptr = mem_q[95:64];
   assign q_up  = mem_q[63:32];
   assign q_lo  = mem_q[31:0];

   ////////////////////////////////////////////////////////////////////////////
   // pointer halves follow the word order setting; the upper half reads zero
   assign ptr_a = WORD_SWAP_CFG ? q_ptr : `HTDV_RST_WORD;
   assign ptr_b = WORD_SWAP_CFG ? `HTDV_RST_WORD : q_ptr;

   // read mux; control halves sit at fixed offsets whatever the order setting
   always_comb begin
      unique case (reg_hit)
         HTDV_REG_PTR_A: rdata_next = ptr_a;
         HTDV_REG_PTR_B: rdata_next = ptr_b;
         HTDV_REG_UP:    rdata_next = q_up;
         HTDV_REG_LO:    rdata_next = q_lo;
         HTDV_REG_SEL:   rdata_next = {31'h0000_0000, sel_reg};
         HTDV_REG_NONE:  rdata_next = `HTDV_RST_WORD;
         default:        rdata_next = `HTDV_RST_WORD;
      endcase
   end

   // read data stand only in the cycle after the strobe
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) RDATA <= `HTDV_RST_WORD;
      else        RDATA <= RD ? rdata_next : `HTDV_RST_WORD;
   end

   ////////////////////////////////////////////////////////////////////////////
   // bus attributes of the selected tank for the access kind at hand
   assign ctx_next = (SPLIT_OUT_CFG && ACC_DATA_WRITE) ? q_lo[`HTDV_LO_OCTX_HI:`HTDV_LO_OCTX_LO]
                                                       : q_lo[`HTDV_LO_PCTX_HI:`HTDV_LO_PCTX_LO];
   assign dom_next = (SPLIT_OUT_CFG && ACC_DATA_WRITE) ? q_lo[`HTDV_LO_ODOM_HI:`HTDV_LO_ODOM_LO]
                                                       : q_lo[`HTDV_LO_PDOM_HI:`HTDV_LO_PDOM_LO];
   assign src_rsvd_next = !(q_up[`HTDV_UP_SRC_HI:`HTDV_UP_SRC_LO] inside
                            {HTDV_SRC_RING0, HTDV_SRC_RING1, HTDV_SRC_RING2, HTDV_SRC_CHECKER});

   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         VIEW_ATTR_CTX  <= 11'h000;
         VIEW_ATTR_DOM  <= 4'h0;
         VIEW_ATTR_SEC  <= 1'b0;
         VIEW_SRC_RSVD  <= 1'b0;
         VIEW_FULL_DESC <= 1'b0;
      end else begin
         VIEW_ATTR_CTX  <= ctx_next;
         VIEW_ATTR_DOM  <= dom_next;
         VIEW_ATTR_SEC  <= q_lo[`HTDV_LO_PSEC];
         VIEW_SRC_RSVD  <= src_rsvd_next;
         // whole flag alone: with or without frame data the complete descriptor is held
         VIEW_FULL_DESC <= q_up[`HTDV_UP_WHOLE];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   chk_sel_clamp: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      sel_wr && (32'(wr_sel_val) >= NUM_TANKS) |=> sel_reg == 1'b0)
      else $error("select past last tank not stored as zero");

   chk_view_write_ignored: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      WR && reg_hit != HTDV_REG_SEL |=> $stable(sel_reg))
      else $error("write to a view register changed the select");

   chk_upper_layout: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      RD && reg_hit == HTDV_REG_UP |=> RDATA[31:30] == 2'h0 && RDATA[21:20] == 2'h0 && RDATA[14:11] == 4'h0
      && RDATA[7:3] == 5'h0)
      else $error("reserved upper bits not zero");

   chk_upper_fixed: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      RD && reg_hit == HTDV_REG_UP |=> RDATA == $past(q_up))
      else $error("upper half read wrong word");

   chk_lower_fixed: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      RD && reg_hit == HTDV_REG_LO |=> RDATA == $past(q_lo) && RDATA[20] == 1'b0)
      else $error("lower half read wrong word");

   chk_prefetch_off: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      !PREFETCH && RD && reg_hit == HTDV_REG_UP |=> RDATA[18:16] == 3'h0)
      else $error("prefetch fields set without prefetch");

   chk_ptr_reserved: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      RD && ((reg_hit == HTDV_REG_PTR_A && !WORD_SWAP_CFG) || (reg_hit == HTDV_REG_PTR_B && WORD_SWAP_CFG))
      |=> RDATA == 32'h0000_0000)
      else $error("pointer upper half not zero");

   chk_data_one_cycle: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      !RD |=> RDATA == 32'h0000_0000)
      else $error("read data outside the answer cycle");

   chk_out_attr: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      SPLIT_OUT_CFG && ACC_DATA_WRITE |=> VIEW_ATTR_CTX == $past(q_lo[31:21]) && VIEW_ATTR_DOM == $past(q_lo[19:16]))
      else $error("split data write did not use output attributes");

   chk_prim_attr: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      !(SPLIT_OUT_CFG && ACC_DATA_WRITE) |=> VIEW_ATTR_CTX == $past(q_lo[15:5])
      && VIEW_ATTR_DOM == $past(q_lo[3:0]) && VIEW_ATTR_SEC == $past(q_lo[4]))
      else $error("primary attributes not used");

   chk_load_visible: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      LOAD && LOAD_TANK == sel_next && !sel_wr ##1 !LOAD && !sel_wr ##1 RD && reg_hit == HTDV_REG_UP
      |=> RDATA[2:0] == $past(LOAD_JOB_TAG, 3))
      else $error("loaded job tag not visible");

   // registered flags agree with the word that a read returns in the same cycle
   chk_full_desc_flag: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      RD && reg_hit == HTDV_REG_UP |=> VIEW_FULL_DESC == RDATA[`HTDV_UP_WHOLE])
      else $error("full descriptor flag differs from whole bit");

   chk_src_flag: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      RD && reg_hit == HTDV_REG_UP |=> VIEW_SRC_RSVD == (RDATA[10:8] inside {3'h3, 3'h5, 3'h6, 3'h7}))
      else $error("reserved source flag differs from source field");

   chk_sec_attr: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      RD && reg_hit == HTDV_REG_LO |=> VIEW_ATTR_SEC == RDATA[`HTDV_LO_PSEC])
      else $error("secure world output differs from stored bit");

   chk_ptr_order: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      RD && ((reg_hit == HTDV_REG_PTR_B && !WORD_SWAP_CFG) || (reg_hit == HTDV_REG_PTR_A && WORD_SWAP_CFG))
      |=> RDATA == $past(q_ptr))
      else $error("pointer address word in wrong place");

   chk_unmapped_zero: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      RD && reg_hit == HTDV_REG_NONE |=> RDATA == 32'h0000_0000)
      else $error("unmapped read not zero");

   cov_swap_ptr:   cover property (@(posedge SYS_CLK) disable iff (!RST_N) RD && reg_hit == HTDV_REG_PTR_A && WORD_SWAP_CFG);
   cov_sel_switch: cover property (@(posedge SYS_CLK) disable iff (!RST_N) sel_wr ##1 RD && reg_hit == HTDV_REG_UP);
   cov_split_wr:   cover property (@(posedge SYS_CLK) disable iff (!RST_N) SPLIT_OUT_CFG && ACC_DATA_WRITE);
   cov_full_desc:  cover property (@(posedge SYS_CLK) disable iff (!RST_N) VIEW_FULL_DESC);
   cov_src_rsvd:   cover property (@(posedge SYS_CLK) disable iff (!RST_N) VIEW_SRC_RSVD);

endmodule : htdv_view

// file: tb/tb_htdv_view.sv
// self-checking testbench of the holding tank debug view
`timescale 1ns/1ps
`include "htdv_cfg.svh"

module tb_htdv_view;
   import htdv_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // stimulus and observed signals
   logic        sys_clk, rst_n, wr, rd, load, load_tank, whole, four, imm, dword, shared_or_burst_flag, trust, psec;
   logic        word_swap, split_out, data_write, attr_sec, src_rsvd, full_desc;
   logic [11:0] addr;
   logic [31:0] wdata, rdata, sd_ptr;
   logic [4:0]  share;
   logic [1:0]  err;
   logic [2:0]  src, tag;
   logic [10:0] octx, pctx, attr_ctx;
   logic [3:0]  odom, pdom, attr_dom;
   logic [31:0] rdv;
   int          mismatches;
   int          cmp_count;

   // tank contents used throughout: pointer, upper and lower words
   localparam logic [31:0] P0 = 32'h8000_1234, U0 = 32'h1234_5675, L0 = 32'hA5A5_5A5A;
   localparam logic [31:0] P1 = 32'h0FED_CBA8, U1 = 32'hFFFF_FFFF, L1 = 32'h9B3A_C5E7;
   localparam logic [31:0] UP_MASK = 32'h3FCF_8707, LO_MASK = 32'hFFEF_FFFF;

   htdv_view i_dut (
      .SYS_CLK(sys_clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
      .LOAD(load), .LOAD_TANK(load_tank), .LOAD_SD_PTR(sd_ptr), .LOAD_WHOLE(whole), .LOAD_FOUR(four),
      .LOAD_IMM_SWAP(imm), .LOAD_SHARE_SRC(share), .LOAD_DWORD_ORDER(dword), .LOAD_ERR(err),
      .LOAD_SOB(shared_or_burst_flag), .LOAD_ALLOW_TRUSTED(trust), .LOAD_JOB_SRC(src), .LOAD_JOB_TAG(tag),
      .LOAD_OUT_CTX(octx), .LOAD_OUT_DOM(odom), .LOAD_PRIM_CTX(pctx), .LOAD_PRIM_SEC(psec),
      .LOAD_PRIM_DOM(pdom), .WORD_SWAP_CFG(word_swap), .SPLIT_OUT_CFG(split_out),
      .ACC_DATA_WRITE(data_write), .VIEW_ATTR_CTX(attr_ctx), .VIEW_ATTR_DOM(attr_dom),
      .VIEW_ATTR_SEC(attr_sec), .VIEW_SRC_RSVD(src_rsvd), .VIEW_FULL_DESC(full_desc)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // clock, 25 ns period
   always #12.5 sys_clk = ~sys_clk;

   // compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // one-cycle write strobe
   task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      wr    <= 1'b1;
      addr  <= a;
      wdata <= d;
      @(posedge sys_clk);
      wr    <= 1'b0;
   endtask : wr_reg

   // one-cycle read strobe, data taken in the following cycle
   task automatic rd_reg(input logic [11:0] a, output logic [31:0] d);
      @(posedge sys_clk);
      rd   <= 1'b1;
      addr <= a;
      @(posedge sys_clk);
      rd   <= 1'b0;
      #1;
      d = rdata;
   endtask : rd_reg

   // read and compare in one call
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
      rd_reg(a, rdv);
      chk(rdv, exp);
   endtask : rd_chk

   // load one tank from packed upper and lower words
   task automatic load_tank_w(input logic t, input logic [31:0] p, input logic [31:0] u, input logic [31:0] l);
      @(posedge sys_clk);
      load <= 1'b1; load_tank <= t; sd_ptr <= p;
      whole <= u[29]; four <= u[28]; imm <= u[27]; share <= u[26:22]; dword <= u[19];
      err <= u[18:17]; shared_or_burst_flag <= u[16]; trust <= u[15]; src <= u[10:8]; tag <= u[2:0];
      octx <= l[31:21]; odom <= l[19:16]; pctx <= l[15:5]; psec <= l[4]; pdom <= l[3:0];
      @(posedge sys_clk);
      load <= 1'b0;
   endtask : load_tank_w

   // counts, then the verdict
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : give_verdict

   ////////////////////////////////////////////////////////////////////////////////
   // watchdog, far beyond the two hundred or so cycles the tests need
   initial begin
      repeat (20000) @(posedge sys_clk);
      mismatches++;
      give_verdict();
   end

   // main sequence
   initial begin
      logic [11:0] alist [5];
      logic [31:0] u;
      alist = '{12'h008, 12'h00C, 12'h010, 12'h014, 12'h024};
      sys_clk = 1'b0; rst_n = 1'b0; wr = 1'b0; rd = 1'b0; addr = '0; wdata = '0; load = 1'b0;
      load_tank = 1'b0; sd_ptr = '0; whole = 1'b0; four = 1'b0; imm = 1'b0; share = '0; dword = 1'b0;
      err = '0; shared_or_burst_flag = 1'b0; trust = 1'b0; src = '0; tag = '0; octx = '0; odom = '0; pctx = '0;
      psec = 1'b0; pdom = '0; word_swap = 1'b0; split_out = 1'b0; data_write = 1'b0;
      mismatches = 0; cmp_count = 0;
      repeat (6) @(posedge sys_clk);
      rst_n <= 1'b1;
      // registers read zero after reset
      foreach (alist[i]) rd_chk(alist[i], 32'h0000_0000);
      $display("test reset_values done");
      // both tanks loaded, select moves both halves
      load_tank_w(1'b0, P0, U0, L0);
      load_tank_w(1'b1, P1, U1, L1);
      rd_chk(`HTDV_OFS_CTRL_UP, U0 & UP_MASK);
      rd_chk(`HTDV_OFS_CTRL_LO, L0 & LO_MASK);
      wr_reg(`HTDV_OFS_SEL, 32'h0000_0001);
      rd_chk(`HTDV_OFS_SEL, 32'h0000_0001);
      rd_chk(`HTDV_OFS_CTRL_UP, U1 & UP_MASK);
      rd_chk(`HTDV_OFS_CTRL_LO, L1 & LO_MASK);
      rd_chk(12'h030, 32'h0000_0000);
      $display("test tank_select done");
      // pointer word order follows the swap setting, control halves do not
      rd_chk(`HTDV_OFS_PTR_A, 32'h0000_0000);
      rd_chk(`HTDV_OFS_PTR_B, P1);
      @(posedge sys_clk);
      word_swap <= 1'b1;
      rd_chk(`HTDV_OFS_PTR_A, P1);
      rd_chk(`HTDV_OFS_PTR_B, 32'h0000_0000);
      rd_chk(`HTDV_OFS_CTRL_UP, U1 & UP_MASK);
      rd_chk(`HTDV_OFS_CTRL_LO, L1 & LO_MASK);
      $display("test pointer_order done");
      // writes to the view leave it unchanged
      foreach (alist[i]) if (i < 4) wr_reg(alist[i], 32'h0000_0000);
      rd_chk(`HTDV_OFS_PTR_A, P1);
      rd_chk(`HTDV_OFS_CTRL_UP, U1 & UP_MASK);
      rd_chk(`HTDV_OFS_CTRL_LO, L1 & LO_MASK);
      @(posedge sys_clk);
      word_swap <= 1'b0;
      $display("test read_only done");
      // every job source code on tank 0
      wr_reg(`HTDV_OFS_SEL, 32'h0000_0000);
      for (int i = 0; i < 8; i++) begin
         u = U0;
         u[10:8] = i[2:0];
         load_tank_w(1'b0, P0, u, L0);
         rd_chk(`HTDV_OFS_CTRL_UP, u & UP_MASK);
         repeat (3) @(posedge sys_clk);
         chk({31'h0, src_rsvd}, {31'h0, (i == 3 || i >= 5)});
      end
      $display("test job_source done");
      // error codes with the four whole and shared combinations
      for (int i = 0; i < 4; i++) begin
         u = U0;
         u[18:17] = i[1:0];
         u[29] = i[0];
         u[16] = i[1];
         load_tank_w(1'b0, P0, u, L0);
         rd_chk(`HTDV_OFS_CTRL_UP, u & UP_MASK);
         repeat (3) @(posedge sys_clk);
         chk({31'h0, full_desc}, {31'h0, i[0]});
      end
      $display("test prefetch_state done");
      // bus attributes of tank 1 under each split and access setting
      wr_reg(`HTDV_OFS_SEL, 32'h0000_0001);
      for (int i = 0; i < 4; i++) begin
         split_out  <= i[0];
         data_write <= i[1];
         repeat (4) @(posedge sys_clk);
         if (i == 3) begin
            chk({21'h0, attr_ctx}, {21'h0, L1[31:21]});
            chk({28'h0, attr_dom}, {28'h0, L1[19:16]});
         end else begin
            chk({21'h0, attr_ctx}, {21'h0, L1[15:5]});
            chk({28'h0, attr_dom}, {28'h0, L1[3:0]});
         end
         chk({31'h0, attr_sec}, {31'h0, L1[4]});
      end
      $display("test attributes done");
      give_verdict();
   end

endmodule : tb_htdv_view
